// *** ufc_pkg.sv ***
// Purpose: Shared constants and types for the serial receive checker
// Assumes: AHB-Lite register port, 32-bit words, single clock mclk
// Notes:   Byte addresses are four times the printed register index
package ufc_pkg;

  // Printed register indexes; byte address is index times four
  localparam logic [7:0]  OWN_ADDR_IDX   = 8'hA9;
  localparam logic [7:0]  ADDR_MASK_IDX  = 8'hB9;
  localparam logic [7:0]  SER_CTRL_IDX   = 8'h98;
  localparam logic [7:0]  PWR_CTRL_IDX   = 8'h87;
  localparam logic [7:0]  BAUD_SEL_IDX   = 8'h9B;
  localparam logic [7:0]  IRQ_STAT_IDX   = 8'hF0;
  localparam logic [7:0]  IRQ_EN_IDX     = 8'hF1;
  localparam logic [7:0]  IRQ_CLR_IDX    = 8'hF2;

  localparam logic [7:0]  OWN_ADDR_RST   = 8'h00;
  localparam logic [7:0]  ADDR_MASK_RST  = 8'h00;

  // Serial control field positions
  localparam int SC_B7   = 7;
  localparam int SC_SM1  = 6;
  localparam int SC_MPE  = 5;
  localparam int SC_REN  = 4;
  localparam int SC_RB8  = 2;
  localparam int SC_RI   = 0;
  // Power control: frame check enable
  localparam int PC_FCE  = 6;
  // Baud select fields
  localparam int BS_TX_T2  = 0;
  localparam int BS_RX_T2  = 1;
  localparam int BS_TX_GEN = 2;
  localparam int BS_RX_GEN = 3;
  // Interrupt status bits
  localparam int IRQ_RX  = 0;
  localparam int IRQ_FE  = 1;
  localparam int IRQ_W   = 2;

  typedef enum logic [1:0] {
    UFC_SRC_T1  = 2'h0,
    UFC_SRC_T2  = 2'h1,
    UFC_SRC_GEN = 2'h2
  } ufc_src_t;

  // One received frame as handed over by the shift engine
  typedef struct packed {
    logic       last_data;   // Pulse at last data bit sample
    logic       stop_time;   // Pulse at stop bit sample
    logic [7:0] data;        // Eight data bits
    logic       ninth;       // Ninth bit, modes 2 and 3
    logic       stop_ok;     // Stop bit sampled high
  } ufc_frame_t;

endpackage

// *** ufc_rx_check.sv ***
// Purpose: Frame error detection, address filtering and baud source select
// Assumes: Shift engine supplies frame events synchronous to mclk
// Notes:   AHB-Lite slave, zero wait states, always OKAY
////////////////////////////////////////////////////////////////////////////
//
// The implementer's own choice: the AHB-Lite register port.
module ufc_rx_check
  import ufc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire ufc_frame_t  rx_frame,
  input  wire logic        tmr1_baud,
  input  wire logic        tmr2_baud,
  input  wire logic        gen_baud,
  output logic             tx_baud_tick,
  output logic             rx_baud_tick,
  output ufc_src_t         tx_src,
  output ufc_src_t         rx_src,
  output logic             rx_data_valid,
  output logic      [7:0]  rx_data,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]         own_addr_reg_r;
  logic [7:0]         addr_mask_reg_r;
  logic               mode_bit_zero_r;
  logic               mode_bit_one_r;
  logic               multiproc_enable_r;
  logic               rx_enable_r;
  logic               rx_ninth_bit_r;
  logic               rx_done_flag_r;
  logic               frame_err_flag_r;
  logic               frame_check_enable_r;
  logic [3:0]         baud_sel_r;
  logic [IRQ_W-1:0]   irq_stat_r;
  logic [IRQ_W-1:0]   irq_en_r;
  logic               wr_pend_r;
  logic [7:0]         wr_idx_r;
  logic               rd_pend_r;
  logic [7:0]         rd_idx_r;

  function automatic logic idx_ok(input logic [31:0] a);
    idx_ok = (a[1:0] == 2'h0) && (a[31:10] == 22'h0);
  endfunction

  // Masked compare: only positions with a one in care are compared
  function automatic logic masked_eq(input logic [7:0] a,
                                     input logic [7:0] ref_v,
                                     input logic [7:0] care);
    masked_eq = ((a ^ ref_v) & care) == 8'h00;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait, write data taken in the data phase
  logic bus_go;
  assign bus_go    = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      wr_idx_r  <= 8'h00;
      rd_idx_r  <= 8'h00;
    end else begin
      wr_pend_r <= bus_go && hwrite && idx_ok(haddr);
      rd_pend_r <= bus_go && !hwrite;
      wr_idx_r  <= haddr[9:2];
      rd_idx_r  <= idx_ok(haddr) ? haddr[9:2] : 8'h00;
    end
  end

  logic wr_sc;
  logic wr_pc;
  logic wr_clr;
  assign wr_sc  = wr_pend_r && (wr_idx_r == SER_CTRL_IDX);
  assign wr_pc  = wr_pend_r && (wr_idx_r == PWR_CTRL_IDX);
  assign wr_clr = wr_pend_r && (wr_idx_r == IRQ_CLR_IDX);

  ////////////////////////////////////////////////////////////////////////
  // Receive decision
  logic [1:0] mode;
  logic       async_mode;
  logic       check_on;
  logic       filter_on;
  logic       ninth_in;
  logic       is_addr;
  logic       match;
  logic       rx_evt;
  logic       accept;
  logic       fe_set;

  assign mode       = {mode_bit_zero_r, mode_bit_one_r};
  assign async_mode = (mode != 2'd0);
  assign check_on   = frame_check_enable_r && async_mode;
  assign filter_on  = multiproc_enable_r && async_mode;
  // Mode 1 uses the stop bit as the ninth bit
  assign ninth_in   = (mode == 2'd1) ? rx_frame.stop_ok
                                     : rx_frame.ninth;
  assign is_addr    = ninth_in;
  assign match      = masked_eq(rx_frame.data, own_addr_reg_r,
                                addr_mask_reg_r)
                   || masked_eq(rx_frame.data,
                                own_addr_reg_r | addr_mask_reg_r,
                                own_addr_reg_r | addr_mask_reg_r);
  // Checking moves the decision point to the stop bit sample
  assign rx_evt     = rx_enable_r &&
                      (check_on ? rx_frame.stop_time
                                : rx_frame.last_data);
  assign accept     = rx_evt && !rx_done_flag_r &&
                      (!filter_on || (is_addr && match &&
                       ((mode != 2'd1) || rx_frame.stop_ok)));
  assign fe_set     = check_on && rx_enable_r && rx_frame.stop_time &&
                      !rx_frame.stop_ok;

  ////////////////////////////////////////////////////////////////////////
  // Serial control and power control
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_bit_zero_r      <= 1'b0;
      mode_bit_one_r       <= 1'b0;
      multiproc_enable_r   <= 1'b0;
      rx_enable_r          <= 1'b0;
      frame_check_enable_r <= 1'b0;
    end else begin
      if (wr_sc) begin
        if (!frame_check_enable_r)
          mode_bit_zero_r  <= hwdata[SC_B7];
        mode_bit_one_r     <= hwdata[SC_SM1];
        multiproc_enable_r <= hwdata[SC_MPE];
        rx_enable_r        <= hwdata[SC_REN];
      end
      if (wr_pc)
        frame_check_enable_r <= hwdata[PC_FCE];
    end
  end

  // Frame error flag: hardware set wins over software clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      frame_err_flag_r <= 1'b0;
    end else if (fe_set) begin
      frame_err_flag_r <= 1'b1;
    end else if (wr_sc && frame_check_enable_r && !hwdata[SC_B7]) begin
      frame_err_flag_r <= 1'b0;
    end
  end

  // Receive done flag and ninth bit; a held flag blocks overwrite
  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_done_flag_r <= 1'b0;
      rx_ninth_bit_r <= 1'b0;
      rx_data        <= 8'h00;
    end else if (accept) begin
      rx_done_flag_r <= 1'b1;
      rx_ninth_bit_r <= ninth_in;
      rx_data        <= rx_frame.data;
    end else if (wr_sc) begin
      rx_done_flag_r <= hwdata[SC_RI];
      rx_ninth_bit_r <= hwdata[SC_RB8];
    end
  end
  assign rx_data_valid = rx_done_flag_r;

  ////////////////////////////////////////////////////////////////////////
  // Address, mask and baud select registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      own_addr_reg_r  <= OWN_ADDR_RST;
      addr_mask_reg_r <= ADDR_MASK_RST;
      baud_sel_r      <= 4'h0;
    end else if (wr_pend_r) begin
      if (wr_idx_r == OWN_ADDR_IDX)
        own_addr_reg_r <= hwdata[7:0];
      if (wr_idx_r == ADDR_MASK_IDX)
        addr_mask_reg_r <= hwdata[7:0];
      if (wr_idx_r == BAUD_SEL_IDX)
        baud_sel_r <= hwdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Baud source selection; tx and rx paths are independent
  function automatic ufc_src_t pick_src(input logic gen_sel,
                                        input logic t2_sel);
    if (gen_sel)
      pick_src = UFC_SRC_GEN;
    else if (t2_sel)
      pick_src = UFC_SRC_T2;
    else
      pick_src = UFC_SRC_T1;
  endfunction

  function automatic logic src_tick(input ufc_src_t s, input logic t1,
                                    input logic t2, input logic g);
    case (s)
      UFC_SRC_GEN: src_tick = g;
      UFC_SRC_T2:  src_tick = t2;
      default:     src_tick = t1;
    endcase
  endfunction

  assign tx_src = pick_src(baud_sel_r[BS_TX_GEN],
                           baud_sel_r[BS_TX_T2]);
  assign rx_src = pick_src(baud_sel_r[BS_RX_GEN],
                           baud_sel_r[BS_RX_T2]);
  assign tx_baud_tick = src_tick(tx_src, tmr1_baud, tmr2_baud, gen_baud);
  assign rx_baud_tick = src_tick(rx_src, tmr1_baud, tmr2_baud, gen_baud);

  ////////////////////////////////////////////////////////////////////////
  // Interrupts: set wins over clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_stat_r <= '0;
      irq_en_r   <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~({IRQ_W{wr_clr}} & hwdata[IRQ_W-1:0]))
                  | {fe_set, accept};
      if (wr_pend_r && (wr_idx_r == IRQ_EN_IDX))
        irq_en_r <= hwdata[IRQ_W-1:0];
    end
  end
  assign irq = |(irq_stat_r & irq_en_r);

  ////////////////////////////////////////////////////////////////////////
  // Read data, decoded combinationally in the data phase from the registered index
  logic [7:0] sc_val;
  assign sc_val = {frame_check_enable_r ? frame_err_flag_r
                                        : mode_bit_zero_r,
                   mode_bit_one_r, multiproc_enable_r, rx_enable_r,
                   1'b0, rx_ninth_bit_r, 1'b0, rx_done_flag_r};

  always_comb begin
    hrdata = 32'h0;
    if (rd_pend_r) begin
      case (rd_idx_r)
        OWN_ADDR_IDX:  hrdata[7:0] = own_addr_reg_r;
        ADDR_MASK_IDX: hrdata[7:0] = addr_mask_reg_r;
        SER_CTRL_IDX:  hrdata[7:0] = sc_val;
        PWR_CTRL_IDX:  hrdata[PC_FCE] = frame_check_enable_r;
        BAUD_SEL_IDX:  hrdata[3:0] = baud_sel_r;
        IRQ_STAT_IDX:  hrdata[IRQ_W-1:0] = irq_stat_r;
        IRQ_EN_IDX:    hrdata[IRQ_W-1:0] = irq_en_r;
        default:       hrdata = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  fe_sticky_a: assert property (@(posedge mclk) disable iff (srst)
    frame_err_flag_r && !(wr_sc && !hwdata[SC_B7]) |=> frame_err_flag_r)
    else $error("frame error flag lost");
  fe_set_a: assert property (@(posedge mclk) disable iff (srst)
    fe_set |=> frame_err_flag_r && irq_stat_r[IRQ_FE])
    else $error("bad stop bit not flagged");
  no_check_a: assert property (@(posedge mclk) disable iff (srst)
    (mode == 2'd0) |-> !fe_set)
    else $error("frame check in mode 0");
  ri_time_a: assert property (@(posedge mclk) disable iff (srst)
    check_on && rx_frame.last_data && !rx_frame.stop_time |-> !accept)
    else $error("done raised at data bit");
  filt_a: assert property (@(posedge mclk) disable iff (srst)
    filter_on && accept |-> is_addr && match)
    else $error("unmatched address accepted");
  mode1_a: assert property (@(posedge mclk) disable iff (srst)
    filter_on && (mode == 2'd1) && accept |-> rx_frame.stop_ok)
    else $error("mode 1 accept without stop");
  mode0_a: assert property (@(posedge mclk) disable iff (srst)
    (mode == 2'd0) && rx_evt && !rx_done_flag_r |-> accept)
    else $error("mode 0 filtered");
  reset_a: assert property (@(posedge mclk)
    srst |=> own_addr_reg_r == 8'h00 && addr_mask_reg_r == 8'h00)
    else $error("address regs not cleared");
  tx_src_a: assert property (@(posedge mclk) disable iff (srst)
    baud_sel_r[BS_TX_GEN] |-> tx_baud_tick == gen_baud)
    else $error("tx source wrong");
  rx_src_a: assert property (@(posedge mclk) disable iff (srst)
    !baud_sel_r[BS_RX_GEN] && baud_sel_r[BS_RX_T2]
      |-> rx_baud_tick == tmr2_baud)
    else $error("rx source wrong");

  // Given and broadcast paths checked apart so a dead path shows up
  given_hit_a: assert property (@(posedge mclk) disable iff (srst)
    rx_evt && !rx_done_flag_r && filter_on && is_addr &&
    ((mode != 2'd1) || rx_frame.stop_ok) &&
    (((rx_frame.data ^ own_addr_reg_r) & addr_mask_reg_r) == 8'h00) |-> accept)
    else $error("given address missed");
  bcast_hit_a: assert property (@(posedge mclk) disable iff (srst)
    rx_evt && !rx_done_flag_r && filter_on && is_addr &&
    ((mode != 2'd1) || rx_frame.stop_ok) &&
    ((rx_frame.data | ~(own_addr_reg_r | addr_mask_reg_r)) == 8'hFF)
      |-> accept)
    else $error("broadcast address missed");
  data_drop_a: assert property (@(posedge mclk) disable iff (srst)
    filter_on && (mode != 2'd1) && !rx_frame.ninth |-> !accept)
    else $error("data frame passed filter");
  done_set_a: assert property (@(posedge mclk) disable iff (srst)
    accept |=> rx_done_flag_r && rx_data_valid && irq_stat_r[IRQ_RX])
    else $error("receive done not raised");
  done_late_a: assert property (@(posedge mclk) disable iff (srst)
    check_on && rx_frame.stop_time && rx_enable_r && !rx_done_flag_r &&
    !filter_on |-> accept)
    else $error("done missing at stop bit");
  ninth_cap_a: assert property (@(posedge mclk) disable iff (srst)
    accept && (mode == 2'd1) && !multiproc_enable_r
      |=> rx_ninth_bit_r == $past(rx_frame.stop_ok))
    else $error("stop bit not captured");
  fe_clear_a: assert property (@(posedge mclk) disable iff (srst)
    wr_sc && frame_check_enable_r && !hwdata[SC_B7] && !fe_set
      |=> !frame_err_flag_r)
    else $error("frame error not cleared");
  mode_keep_a: assert property (@(posedge mclk) disable iff (srst)
    wr_sc && frame_check_enable_r
      |=> mode_bit_zero_r == $past(mode_bit_zero_r))
    else $error("mode bit changed by error write");
  fe_read_a: assert property (@(posedge mclk) disable iff (srst)
    rd_pend_r && (rd_idx_r == SER_CTRL_IDX) && frame_check_enable_r
      |-> hrdata[SC_B7] == frame_err_flag_r)
    else $error("bit 7 not showing frame error");
  check_off_a: assert property (@(posedge mclk) disable iff (srst)
    !frame_check_enable_r |-> !fe_set)
    else $error("frame check while disabled");
  tx_t1_a: assert property (@(posedge mclk) disable iff (srst)
    !baud_sel_r[BS_TX_GEN] && !baud_sel_r[BS_TX_T2]
      |-> tx_baud_tick == tmr1_baud)
    else $error("tx timer 1 not used");
  tx_t2_a: assert property (@(posedge mclk) disable iff (srst)
    !baud_sel_r[BS_TX_GEN] && baud_sel_r[BS_TX_T2]
      |-> tx_baud_tick == tmr2_baud)
    else $error("tx timer 2 not used");
  rx_t1_a: assert property (@(posedge mclk) disable iff (srst)
    !baud_sel_r[BS_RX_GEN] && !baud_sel_r[BS_RX_T2]
      |-> rx_baud_tick == tmr1_baud)
    else $error("rx timer 1 not used");
  rx_gen_a: assert property (@(posedge mclk) disable iff (srst)
    baud_sel_r[BS_RX_GEN]
      |-> rx_baud_tick == gen_baud)
    else $error("rx generator not used");
  irq_clr_a: assert property (@(posedge mclk) disable iff (srst)
    wr_clr && hwdata[IRQ_RX] && !accept |=> !irq_stat_r[IRQ_RX])
    else $error("status bit not cleared");

endmodule

// *** ufc_remote_node.sv ***
// Purpose: Remote serial node handing frames to the receive checker
// Assumes: Bench commands one frame at a time with go
// Notes:   Fields show inverted values once a frame has ended
module ufc_remote_node
  import ufc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       go,
  input  wire logic [9:0] word,
  output ufc_frame_t      frame
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] ph_r = 2'h0;
  initial frame = '0;
  // Last data pulse, then stop pulse; fields hold across both
  always @(posedge mclk) begin
    ph_r <= go ? 2'h1 : (ph_r == 2'h0 ? 2'h0 : ph_r + 2'h1);
    frame.last_data <= (ph_r == 2'h1);
    frame.stop_time <= (ph_r == 2'h2);
    if (go)
      {frame.data, frame.ninth, frame.stop_ok} <= word;
    else if (ph_r == 2'h3)
      {frame.data, frame.ninth, frame.stop_ok} <= ~word;
  end
endmodule

// *** ufc_rx_check_bench.sv ***
// Purpose: Self-checking bench for the receive checker
// Assumes: Zero-wait AHB-Lite slave, remote node model on rx_frame
// Notes:   Each table row starts from a fresh reset
module ufc_rx_check_bench
  import ufc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0] sc;
    logic       fce;
    logic [7:0] own;
    logic [7:0] msk;
    logic [9:0] w;
    logic       done;
    logic       fe;
  } ufc_row_t;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [2:0]  tmr = 3'h0;
  logic        go = 1'b0;
  logic [9:0]  word = 10'h0;
  ufc_frame_t  frame;
  logic        tx_tick;
  logic        rx_tick;
  logic        valid;
  logic        irq;
  ufc_src_t    tx_src;
  ufc_src_t    rx_src;
  logic [7:0]  rx_data;
  int          err_total = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  ufc_row_t rows [13] = '{
    {8'h50, 1'h1, 8'h00, 8'h00, 10'h294, 1'h1, 1'h1},
    {8'h10, 1'h1, 8'h00, 8'h00, 10'h294, 1'h1, 1'h0},
    {8'hB0, 1'h0, 8'h56, 8'hFC, 10'h15F, 1'h1, 1'h0},
    {8'hB0, 1'h0, 8'h56, 8'hFC, 10'h16B, 1'h0, 1'h0},
    {8'hB0, 1'h0, 8'h56, 8'hFC, 10'h3FB, 1'h1, 1'h0},
    {8'hF0, 1'h0, 8'h56, 8'hFC, 10'h15D, 1'h0, 1'h0},
    {8'h70, 1'h0, 8'h56, 8'hFC, 10'h15D, 1'h1, 1'h0},
    {8'h70, 1'h0, 8'h56, 8'hFC, 10'h15C, 1'h0, 1'h0},
    {8'h30, 1'h0, 8'h56, 8'hFC, 10'h16B, 1'h1, 1'h0},
    {8'h90, 1'h0, 8'h56, 8'hFC, 10'h16B, 1'h1, 1'h0},
    {8'hB0, 1'h0, 8'h00, 8'h00, 10'h16B, 1'h1, 1'h0},
    {8'hB0, 1'h0, 8'h33, 8'hFF, 10'h0CF, 1'h1, 1'h0},
    {8'hB0, 1'h0, 8'h33, 8'hFF, 10'h0CB, 1'h0, 1'h0}
  };
  ufc_rx_check u_ufc_rx_check (
    .mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rx_frame(frame), .tmr1_baud(tmr[0]), .tmr2_baud(tmr[1]),
    .gen_baud(tmr[2]), .tx_baud_tick(tx_tick), .rx_baud_tick(rx_tick),
    .tx_src(tx_src), .rx_src(rx_src), .rx_data_valid(valid),
    .rx_data(rx_data), .irq(irq));
  ufc_remote_node u_ufc_remote_node (
    .mclk(mclk), .go(go), .word(word), .frame(frame));
  ////////////////////////////////////////////////////////////////////////
  initial forever #4 mclk = ~mclk;
  // Hang guard; the whole run needs about six hundred cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Address phase held until hready, then data phase until hready
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({7'h0, hresp}, 8'h00);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
    // The write lands at the data phase edge; let it settle first
    @(posedge mclk);
  endtask
  task automatic do_reset();
    srst <= 1'b1;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
  endtask
  // Early is the done flag seen one edge after the last data pulse
  task automatic send(input logic [9:0] w, output logic early);
    go <= 1'b1;
    word <= w;
    @(posedge mclk);
    go <= 1'b0;
    repeat (3) @(posedge mclk);
    early = valid;
    repeat (2) @(posedge mclk);
  endtask
  function automatic logic [1:0] src_of(input logic g, input logic t2);
    return g ? 2'h2 : {1'b0, t2};
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0]  ts;
    logic [1:0]  rs;
    logic        e;
    logic        ee;
    foreach (rows[i]) begin
      do_reset();
      wr(SER_CTRL_IDX, {24'h0, rows[i].sc});
      wr(PWR_CTRL_IDX, {25'h0, rows[i].fce, 6'h0});
      wr(OWN_ADDR_IDX, {24'h0, rows[i].own});
      wr(ADDR_MASK_IDX, {24'h0, rows[i].msk});
      send(rows[i].w, e);
      ee = rows[i].done && !(rows[i].fce && (rows[i].sc[7:6] != 2'h0));
      chk({7'h0, e}, {7'h0, ee});
      chk({7'h0, valid}, {7'h0, rows[i].done});
      bus(1'b0, IRQ_STAT_IDX, 32'h0, d);
      chk({7'h0, d[IRQ_FE]}, {7'h0, rows[i].fe});
      if (rows[i].done)
        chk(rx_data, rows[i].w[9:2]);
      $display("row %0d finished", i);
    end
    // Reset values, read back and an unmapped place
    do_reset();
    bus(1'b0, OWN_ADDR_IDX, 32'h0, d);
    chk(d[7:0], OWN_ADDR_RST);
    bus(1'b0, ADDR_MASK_IDX, 32'h0, d);
    chk(d[7:0], ADDR_MASK_RST);
    wr(OWN_ADDR_IDX, 32'hA5);
    bus(1'b0, OWN_ADDR_IDX, 32'h0, d);
    chk(d[7:0], 8'hA5);
    bus(1'b0, 8'h40, 32'h0, d);
    chk(d[7:0], 8'h00);
    $display("register test finished");
    // Sticky error, bit 7 sharing and the interrupt path
    do_reset();
    wr(SER_CTRL_IDX, 32'h50);
    wr(PWR_CTRL_IDX, 32'h40);
    send(10'h294, e);
    chk({7'h0, irq}, 8'h00);
    wr(IRQ_EN_IDX, 32'h2);
    chk({7'h0, irq}, 8'h01);
    wr(SER_CTRL_IDX, 32'hD0);
    send(10'h16B, e);
    chk({7'h0, e}, 8'h00);
    chk(rx_data, 8'h5A);
    bus(1'b0, SER_CTRL_IDX, 32'h0, d);
    chk({7'h0, d[SC_B7]}, 8'h01);
    wr(IRQ_CLR_IDX, 32'h2);
    chk({7'h0, irq}, 8'h00);
    wr(SER_CTRL_IDX, 32'h50);
    bus(1'b0, SER_CTRL_IDX, 32'h0, d);
    chk({7'h0, d[SC_B7]}, 8'h00);
    wr(PWR_CTRL_IDX, 32'h0);
    wr(SER_CTRL_IDX, 32'hD0);
    bus(1'b0, SER_CTRL_IDX, 32'h0, d);
    chk({7'h0, d[SC_B7]}, 8'h01);
    $display("sticky error test finished");
    // Stop bit lands in the ninth bit field
    do_reset();
    wr(SER_CTRL_IDX, 32'h50);
    send(10'h295, e);
    chk({7'h0, e}, 8'h01);
    bus(1'b0, SER_CTRL_IDX, 32'h0, d);
    chk({7'h0, d[SC_RB8]}, 8'h01);
    $display("ninth bit test finished");
    // Every select code against every tick pattern
    for (int s = 0; s < 16; s++) begin
      wr(BAUD_SEL_IDX, s);
      ts = src_of(s[BS_TX_GEN], s[BS_TX_T2]);
      rs = src_of(s[BS_RX_GEN], s[BS_RX_T2]);
      chk({6'h0, tx_src}, {6'h0, ts});
      chk({6'h0, rx_src}, {6'h0, rs});
      for (int k = 0; k < 8; k++) begin
        tmr <= k[2:0];
        @(posedge mclk);
        chk({7'h0, tx_tick}, {7'h0, tmr[ts]});
        chk({7'h0, rx_tick}, {7'h0, tmr[rs]});
      end
    end
    $display("baud select test finished");
    finish_test();
  end
endmodule
